// File: hdl/ethernet_mac_receiver.sv
// Receive half of a 10/100 MAC: MII sampling, SFD search, CRC, filtering, FIFO, counters.
// Assumes one 100 MHz system clock; the PHY receive clock is sampled as a plain input.
`timescale 1ns/1ps
`include "mac_rx_regs.svh"

module ethernet_mac_receiver #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic clock, // System clock, 100 MHz.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic rx_clk, // Receive clock from the PHY.
   input wire logic [3:0] rxd, // Receive data from the PHY.
   input wire logic rx_dv, // Receive data valid.
   input wire logic rx_er, // Receive error.
   input wire logic crs, // Carrier sense.
   input wire logic col, // Collision detect.
   input wire logic hsel, // AHB-Lite slave select.
   input wire logic [31:0] haddr, // AHB-Lite address.
   input wire logic [1:0] htrans, // AHB-Lite transfer type.
   input wire logic hwrite, // AHB-Lite write flag.
   input wire logic [2:0] hsize, // AHB-Lite size, words only.
   input wire logic [31:0] hwdata, // AHB-Lite write data.
   input wire logic hready, // AHB-Lite bus ready.
   output logic [31:0] hrdata, // AHB-Lite read data.
   output logic hreadyout, // AHB-Lite slave ready.
   output logic hresp, // AHB-Lite response, always OKAY.
   output logic mem_burst_req, // Burst request to local receive memory.
   output logic mem_wvalid, // FIFO word available.
   output logic [31:0] mem_wdata, // FIFO word to memory.
   input wire logic mem_wready, // Memory takes the word.
   input wire logic mem_full, // Local receive memory is full.
   output logic frame_done, // Pulse: frame finished and drained.
   output mac_rx_pkg::frame_status_t frame_status, // Status of the last frame.
   output logic overflow_event, // Pulse: frame lost to memory full.
   output logic rx_error_event, // Pulse: CRC error outside monitor mode.
   output logic counter_alert // Pulse: an event counter reached 192.
);

   // One byte of CRC-32, least significant bit of the byte first.
   function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         c = (c[31] ^ data[i]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // Saturating, clear-on-read event counter step.
   function automatic logic [7:0] count_step(input logic [7:0] c, input logic inc, input logic rd);
      if (rd) begin
         return inc ? 8'h01 : 8'h00;
      end else if (inc && c != `COUNT_MAX) begin
         return c + 8'h01;
      end
      return c;
   endfunction

   // Register file.
   mac_rx_pkg::rx_ctrl_t ctrl;
   logic [15:0] slot_bits;
   logic [47:0] station;
   logic [63:0] hash_table;
   logic [7:0] crc_count;
   logic [7:0] align_count;
   logic [7:0] missed_count;

   // Line sampling.
   logic [8:0] sync1;
   logic [8:0] sync2;
   logic clk_prev;
   logic rx_edge;
   logic [3:0] d_s;
   logic dv_s, er_s, active_s;

   // Frame state.
   mac_rx_pkg::rx_state_t state;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [2:0] bit_cnt;
   logic [2:0] step;
   logic [2:0] next_bit_cnt;
   logic byte_strobe;
   logic frame_end;
   logic [15:0] byte_cnt;
   logic [31:0] crc;
   logic [31:0] next_crc;
   logic [47:0] dest;
   logic [47:0] next_dest;
   logic addr_match;
   logic is_addr_ok;
   logic is_bcast, is_mcast;
   logic storing;
   logic overflowed;
   logic er_seen;
   logic [31:0] pack;
   logic [1:0] lane;

   // FIFO.
   logic [31:0] fifo_mem [FIFO_DEPTH];
   logic [3:0] wr_ptr, rd_ptr, level;
   logic fifo_push, fifo_flush;
   logic [31:0] push_word;
   logic eof_pending;
   mac_rx_pkg::frame_status_t end_status;
   logic crc_inc, align_inc, missed_inc;

   // Bus phase decode.
   logic bus_take;
   logic wr_pend;
   logic [7:0] wr_off;
   logic [7:0] rd_off;
   logic rd_crc, rd_align, rd_missed;

   // The PHY clock and pins are asynchronous; two flops, then edge finding on the second stage.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
         clk_prev <= 1'b0;
      end else begin
         sync1 <= {rx_clk, rx_er, rx_dv, col, crs, rxd};
         sync2 <= sync1;
         clk_prev <= sync2[8];
      end
   end

   // Data travels through the same two stages as the clock, so it is stable at the found edge.
   assign rx_edge = sync2[8] && !clk_prev;
   assign d_s = sync2[3:0];
   assign dv_s = sync2[6];
   assign er_s = sync2[7];
   assign active_s = ctrl.nibble_mode ? dv_s : (sync2[4] || sync2[5]);

   // Shift path: one bit at the top in serial mode, one nibble at the top in nibble mode.
   always_comb begin
      if (ctrl.nibble_mode) begin
         next_shreg = {d_s, shreg[7:4]};
         step = 3'h4;
      end else begin
         next_shreg = {d_s[0], shreg[7:1]};
         step = 3'h1;
      end
      next_bit_cnt = bit_cnt + step;
   end

   // Byte and end events happen only on found receive clock edges while framing.
   assign byte_strobe = rx_edge && state == mac_rx_pkg::ST_DATA && active_s && next_bit_cnt == 3'h0;
   assign frame_end = rx_edge && state == mac_rx_pkg::ST_DATA && !active_s;
   assign next_crc = crc_byte(crc, next_shreg);
   assign next_dest = {next_shreg, dest[47:8]};
   assign is_bcast = next_dest == 48'hFFFF_FFFF_FFFF;
   assign is_mcast = next_dest[0];

   // Filter decision, taken as the sixth destination byte arrives.
   always_comb begin
      if (ctrl.promisc) begin
         addr_match = 1'b1;
      end else if (is_bcast) begin
         addr_match = ctrl.bcast_en || hash_table[next_crc[31:26]];
      end else if (is_mcast) begin
         addr_match = ctrl.mcast_en && hash_table[next_crc[31:26]];
      end else begin
         addr_match = next_dest == station;
      end
   end

   // Receive sequence: idle, SFD hunt, data.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= mac_rx_pkg::ST_IDLE;
         shreg <= 8'h00;
         bit_cnt <= 3'h0;
      end else if (rx_edge) begin
         case (state)
            mac_rx_pkg::ST_IDLE: begin
               shreg <= 8'h00;
               if (active_s) begin
                  shreg <= next_shreg;
                  state <= mac_rx_pkg::ST_HUNT;
               end
            end
            mac_rx_pkg::ST_HUNT: begin
               shreg <= next_shreg;
               bit_cnt <= 3'h0;
               if (!active_s) begin
                  state <= mac_rx_pkg::ST_IDLE;
               end else if (next_shreg == `SFD_BYTE) begin
                  state <= mac_rx_pkg::ST_DATA;
               end
            end
            mac_rx_pkg::ST_DATA: begin
               if (active_s) begin
                  shreg <= next_shreg;
                  bit_cnt <= next_bit_cnt;
               end else begin
                  state <= mac_rx_pkg::ST_IDLE;
               end
            end
            default: state <= mac_rx_pkg::ST_IDLE;
         endcase
      end
   end

   // Per-frame bookkeeping: count, CRC, destination, storing and abort flags.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         byte_cnt <= 16'h0000;
         crc <= `CRC_INIT;
         dest <= 48'h0000_0000_0000;
         storing <= 1'b0;
         overflowed <= 1'b0;
         er_seen <= 1'b0;
         is_addr_ok <= 1'b0;
      end else if (rx_edge && state == mac_rx_pkg::ST_HUNT && active_s && next_shreg == `SFD_BYTE) begin
         byte_cnt <= 16'h0001;
         crc <= `CRC_INIT;
         storing <= !ctrl.monitor;
         overflowed <= 1'b0;
         er_seen <= 1'b0;
         is_addr_ok <= 1'b0;
      end else begin
         if (rx_edge && ctrl.nibble_mode && dv_s && er_s) begin
            er_seen <= 1'b1;
         end
         if (byte_strobe) begin
            crc <= next_crc;
            if (byte_cnt != 16'hFFFF) begin
               byte_cnt <= byte_cnt + 16'h0001;
            end
            if (byte_cnt <= `DEST_BYTES) begin
               dest <= next_dest;
            end
            if (byte_cnt == `DEST_BYTES) begin
               is_addr_ok <= addr_match;
               if (!addr_match) begin
                  storing <= 1'b0;
               end
            end
         end
         if (state == mac_rx_pkg::ST_DATA && storing && mem_full) begin
            storing <= 1'b0;
            overflowed <= 1'b1;
         end
      end
   end

   logic flag_bcast, flag_mcast;

   // Destination class kept for the status word.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flag_bcast <= 1'b0;
         flag_mcast <= 1'b0;
      end else if (byte_strobe && byte_cnt == `DEST_BYTES) begin
         flag_bcast <= is_bcast;
         flag_mcast <= is_mcast && !is_bcast;
      end
   end

   // Frame verdict, formed from the state just before the frame end.
   logic v_crc_bad, v_misaligned, v_long, v_runt, v_accept, v_stored;
   always_comb begin
      v_crc_bad = crc != `CRC_RESIDUE || er_seen;
      v_misaligned = v_crc_bad && bit_cnt != 3'h0;
      v_long = ctrl.long_en && byte_cnt > `LONG_LIMIT + 16'h0001;
      v_runt = byte_cnt <= (slot_bits >> 3);
      v_accept = is_addr_ok && (!v_runt || ctrl.runts_en) && (!v_crc_bad || ctrl.errors_en);
      v_stored = v_accept && storing && !overflowed;
      crc_inc = frame_end && v_crc_bad && !v_long;
      align_inc = frame_end && v_misaligned && !v_long;
      missed_inc = frame_end && (overflowed || (ctrl.monitor && v_accept));
   end

   // Bytes pack little-endian into dwords; a partial dword is flushed at frame end.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pack <= 32'h0000_0000;
         lane <= 2'h0;
      end else if (frame_end || state != mac_rx_pkg::ST_DATA) begin
         pack <= 32'h0000_0000;
         lane <= 2'h0;
      end else if (byte_strobe) begin
         pack[lane*8 +: 8] <= next_shreg;
         lane <= lane + 2'h1;
      end
   end

   // Push a full dword while storing, or the tail of a frame that is kept.
   always_comb begin
      fifo_push = 1'b0;
      push_word = pack;
      if (byte_strobe && storing && lane == 2'h3) begin
         fifo_push = 1'b1;
         push_word = {next_shreg, pack[23:0]};
      end else if (frame_end && v_stored && lane != 2'h0) begin
         fifo_push = 1'b1;
      end
      fifo_flush = (byte_strobe && byte_cnt == `DEST_BYTES && !addr_match) || (frame_end && !v_stored);
   end

   // Eight-dword FIFO; a push while it already holds FIFO_DEPTH words is dropped.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
      end else if (fifo_flush) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
      end else begin
         if (fifo_push && level != 4'(FIFO_DEPTH)) begin
            fifo_mem[wr_ptr[2:0]] <= push_word;
            wr_ptr <= wr_ptr + 4'h1;
         end
         if (mem_wvalid && mem_wready) begin
            rd_ptr <= rd_ptr + 4'h1;
         end
      end
   end

   assign level = wr_ptr - rd_ptr;
   assign mem_wvalid = level != 4'h0;
   assign mem_wdata = fifo_mem[rd_ptr[2:0]];
   assign mem_burst_req = level >= `BURST_LEVEL || (eof_pending && mem_wvalid);

   // Status is posted at every frame end; completion waits for the stored words to drain.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         frame_status <= '0;
         end_status <= '0;
         eof_pending <= 1'b0;
         frame_done <= 1'b0;
         overflow_event <= 1'b0;
         rx_error_event <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         overflow_event <= frame_end && overflowed;
         rx_error_event <= frame_end && v_crc_bad && !ctrl.monitor;
         if (frame_end) begin
            frame_status <= '{v_misaligned, v_crc_bad, overflowed || (ctrl.monitor && v_accept), v_long,
                              v_runt, flag_bcast, flag_mcast, v_stored, byte_cnt};
            eof_pending <= 1'b1;
         end else if (eof_pending && !mem_wvalid) begin
            eof_pending <= 1'b0;
            frame_done <= 1'b1;
         end
      end
   end

   // AHB-Lite slave: zero wait states, OKAY always; read data is captured in the address phase.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign bus_take = hsel && htrans[1] && hready;
   assign rd_off = haddr[7:0];
   assign rd_crc = bus_take && !hwrite && rd_off == `OFF_CRC_COUNT;
   assign rd_align = bus_take && !hwrite && rd_off == `OFF_ALIGN_COUNT;
   assign rd_missed = bus_take && !hwrite && rd_off == `OFF_MISSED_COUNT;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_pend <= 1'b0;
         wr_off <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend <= bus_take && hwrite;
         wr_off <= rd_off;
         if (bus_take && !hwrite) begin
            case (rd_off)
               `OFF_CTRL: hrdata <= {24'h00_0000, ctrl};
               `OFF_SLOT: hrdata <= {16'h0000, slot_bits};
               `OFF_STATION_LO: hrdata <= station[31:0];
               `OFF_STATION_HI: hrdata <= {16'h0000, station[47:32]};
               `OFF_HASH_LO: hrdata <= hash_table[31:0];
               `OFF_HASH_HI: hrdata <= hash_table[63:32];
               `OFF_STATUS: hrdata <= {8'h00, frame_status};
               `OFF_CRC_COUNT: hrdata <= {24'h00_0000, crc_count};
               `OFF_ALIGN_COUNT: hrdata <= {24'h00_0000, align_count};
               `OFF_MISSED_COUNT: hrdata <= {24'h00_0000, missed_count};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Writable settings take the data phase word.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl <= `CTRL_RESET;
         slot_bits <= `SLOT_RESET;
         station <= `STATION_RESET;
         hash_table <= `HASH_RESET;
      end else if (wr_pend) begin
         case (wr_off)
            `OFF_CTRL: ctrl <= hwdata[7:0];
            `OFF_SLOT: slot_bits <= hwdata[15:0];
            `OFF_STATION_LO: station[31:0] <= hwdata;
            `OFF_STATION_HI: station[47:32] <= hwdata[15:0];
            `OFF_HASH_LO: hash_table[31:0] <= hwdata;
            `OFF_HASH_HI: hash_table[63:32] <= hwdata;
            default: ;
         endcase
      end
   end

   // Event counters; an increment in the reading cycle survives as a count of one.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         crc_count <= 8'h00;
         align_count <= 8'h00;
         missed_count <= 8'h00;
         counter_alert <= 1'b0;
      end else begin
         crc_count <= count_step(crc_count, crc_inc, rd_crc);
         align_count <= count_step(align_count, align_inc, rd_align);
         missed_count <= count_step(missed_count, missed_inc, rd_missed);
         counter_alert <= (crc_inc && !rd_crc && crc_count == `COUNT_ALERT - 8'h01) ||
                          (align_inc && !rd_align && align_count == `COUNT_ALERT - 8'h01) ||
                          (missed_inc && !rd_missed && missed_count == `COUNT_ALERT - 8'h01);
      end
   end

endmodule

// File: hdl/mac_rx_regs.svh
// Register offsets, field values, reset values and counts of the receive MAC.
// Included by the package and the receiver; holds definitions only.
`ifndef MAC_RX_REGS_SVH
`define MAC_RX_REGS_SVH

// Byte offsets of the AHB-Lite register words.
`define OFF_CTRL 8'h00
`define OFF_SLOT 8'h04
`define OFF_STATION_LO 8'h08
`define OFF_STATION_HI 8'h0C
`define OFF_HASH_LO 8'h10
`define OFF_HASH_HI 8'h14
`define OFF_STATUS 8'h18
`define OFF_CRC_COUNT 8'h1C
`define OFF_ALIGN_COUNT 8'h20
`define OFF_MISSED_COUNT 8'h24

// Reset values.
`define CTRL_RESET 8'h00
`define SLOT_RESET 16'h0200
`define STATION_RESET 48'h0000_0000_0000
`define HASH_RESET 64'h0000_0000_0000_0000

// Line patterns and CRC constants.
`define SFD_BYTE 8'hD5
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'h04C1_1DB7
`define CRC_RESIDUE 32'hC704_DD7B

// Frame and FIFO figures.
`define DEST_BYTES 16'h0006
`define LONG_LIMIT 16'h05EE
`define FIFO_DEPTH 8
`define BURST_LEVEL 4'h6
`define COUNT_MAX 8'hFF
`define COUNT_ALERT 8'hC0

`endif

// File: hdl/mac_rx_pkg.sv
// Types shared by the receive MAC and its bench.
// Assumes mac_rx_regs.svh is on the include path.
package mac_rx_pkg;
`include "mac_rx_regs.svh"

   // Receive control settings, one bit each.
   typedef struct packed {
      logic long_en;
      logic monitor;
      logic errors_en;
      logic runts_en;
      logic bcast_en;
      logic mcast_en;
      logic promisc;
      logic nibble_mode;
   } rx_ctrl_t;

   // Per-frame status word.
   typedef struct packed {
      logic misaligned;
      logic crc_bad;
      logic missed;
      logic long_frame;
      logic runt;
      logic bcast;
      logic mcast;
      logic stored;
      logic [15:0] count;
   } frame_status_t;

   // Line-side receive sequence.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HUNT,
      ST_DATA
   } rx_state_t;
endpackage

// File: sim/mac_rx_checker.sv
// Concurrent checks on the outputs of the receive MAC.
// Bound into every ethernet_mac_receiver; it sees only that module's ports.
`timescale 1ns/1ps
module mac_rx_checker #(
   parameter int FIFO_DEPTH = 8 // Mirrors the receive FIFO depth.
) (
   input wire logic clock, // System clock.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic mem_burst_req, // Burst request to memory.
   input wire logic mem_wvalid, // FIFO word available.
   input wire logic frame_done, // Frame finished and drained.
   input wire mac_rx_pkg::frame_status_t frame_status, // Status of the last frame.
   input wire logic overflow_event, // Overflow pulse.
   input wire logic rx_error_event // CRC error pulse.
);
   // Every check runs on the system clock and is held off during reset.
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // A single-cycle pulse: high now, low on the next edge.
   sequence s_single(x);
      x ##1 !x;
   endsequence
   a_burst_data: assert property (mem_burst_req |-> mem_wvalid)
      else $error("burst request with an empty FIFO");
   a_done_drained: assert property (frame_done |-> !mem_wvalid)
      else $error("frame done while FIFO still holds words");
   a_done_pulse: assert property (frame_done |-> s_single(frame_done))
      else $error("frame done wider than one cycle");
   a_error_pulse: assert property (rx_error_event |-> s_single(rx_error_event))
      else $error("error event wider than one cycle");
   a_error_crc: assert property (rx_error_event |-> frame_status.crc_bad)
      else $error("error event without CRC status");
   a_ovf_missed: assert property (overflow_event |-> frame_status.missed && !frame_status.stored)
      else $error("overflow without missed status");
   a_ovf_pulse: assert property (overflow_event |-> s_single(overflow_event))
      else $error("overflow event wider than one cycle");
   a_stored_clean: assert property (frame_status.stored |-> !frame_status.missed)
      else $error("stored frame also marked missed");
endmodule

bind ethernet_mac_receiver mac_rx_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
   .clock(clock), .nrst(nrst), .mem_burst_req(mem_burst_req), .mem_wvalid(mem_wvalid),
   .frame_done(frame_done), .frame_status(frame_status), .overflow_event(overflow_event),
   .rx_error_event(rx_error_event));

// File: sim/mii_phy_model.sv
// Behavioural receive side of a PHY on the media independent interface.
// Its clock stands still between frames; data changes on the falling edge.
`timescale 1ns/1ps
module mii_phy_model (
   output logic rx_clk, // Receive clock, 160 ns period in frames.
   output logic [3:0] rxd, // Receive data.
   output logic rx_dv, // Data valid.
   output logic rx_er, // Receive error.
   output logic crs, // Carrier sense.
   output logic col // Collision, never raised here.
);
   // Idle line at start.
   initial begin
      {rx_clk, rxd, rx_dv, rx_er, crs, col} = '0;
   end
   task automatic tick;
      #80 rx_clk = 1'b1;
      #80 rx_clk = 1'b0;
   endtask
   // Sends preamble, delimiter and bytes; in nibble mode an error flag marks both nibbles of queue byte 20.
   task automatic send(input logic [7:0] b[$], input bit nib, input bit er);
      logic [7:0] q[$];
      q = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5, b};
      #3.7;
      crs = !nib;
      rx_dv = nib;
      foreach (q[i]) begin
         if (nib) begin
            for (int h = 0; h < 2; h++) begin
               rxd = q[i][4*h+:4];
               rx_er = er && i == 20;
               tick();
            end
         end else begin
            for (int k = 0; k < 8; k++) begin
               rxd[0] = q[i][k];
               tick();
            end
         end
      end
      // Released control lines drop to zero; rxd must not keep its last value, so it is inverted.
      {crs, rx_dv, rx_er} = '0;
      rxd = ~rxd;
      tick();
   endtask
endmodule

// File: sim/ethernet_mac_receiver_tb.sv
// Self-checking bench for the receive MAC: registers, filters, errors, counters.
// Assumes the package, design, checker and PHY model are compiled before it.
`timescale 1ns/1ps
module ethernet_mac_receiver_tb;
   logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, mem_wready = 1, mem_full = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, mem_wdata, first_w;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, mem_burst_req, mem_wvalid, frame_done, overflow_event, rx_error_event;
   logic counter_alert, rx_clk, rx_dv, rx_er, crs, col, ev_err, ev_ovf, take;
   logic [3:0] rxd;
   logic ev_alt = 0;
   localparam logic [47:0] mc = 48'h0F0E_0D0C_0B03;
   mac_rx_pkg::frame_status_t frame_status;
   int mismatches = 0, samples_checked = 0;
   localparam logic [47:0] me = 48'h0F0E_0D0C_0B02, other = 48'h0F0E_0D0C_0B04, bc = '1;
   mii_phy_model phy_u (.rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .col(col));
   ethernet_mac_receiver dut_u (.clock(clock), .nrst(nrst), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv),
      .rx_er(rx_er), .crs(crs), .col(col), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .mem_burst_req(mem_burst_req), .mem_wvalid(mem_wvalid), .mem_wdata(mem_wdata),
      .mem_wready(mem_wready), .mem_full(mem_full), .frame_done(frame_done), .frame_status(frame_status),
      .overflow_event(overflow_event), .rx_error_event(rx_error_event), .counter_alert(counter_alert));
   always #5 clock = ~clock;
   // Latch event pulses and the first memory word of each frame.
   always @(posedge clock) begin
      if (rx_error_event) ev_err <= 1'b1;
      if (overflow_event) ev_ovf <= 1'b1;
      if (counter_alert) ev_alt <= 1'b1;
      if (take && mem_wvalid && mem_wready) begin
         first_w <= mem_wdata;
         take <= 1'b0;
      end
   end
   task automatic final_report;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One single AHB-Lite transfer; the slave may stretch either phase.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(r, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   // Sends n bytes plus CRC, waits for the frame end, checks masked status flags.
   task automatic frame(input logic [47:0] d, input int n, input bit nib, input bit bad, input bit er,
                        input logic [7:0] m, input logic [7:0] e);
      logic [7:0] q[$];
      logic [31:0] c;
      logic seen;
      c = '1;
      seen = 1'b0;
      for (int i = 0; i < n; i++) begin
         q.push_back(i < 6 ? d[8*i+:8] : i[7:0]);
         c ^= {24'h0, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
      end
      c = ~c ^ {31'h0, bad};
      for (int i = 0; i < 4; i++) q.push_back(c[8*i+:8]);
      {ev_err, ev_ovf, take} = 3'b001;
      fork
         phy_u.send(q, nib, er);
         for (int k = 0; k < 30000 && seen !== 1'b1; k++) begin
            @(posedge clock);
            seen = frame_done;
         end
      join
      chk({31'h0, seen}, 32'h1);
      chk({24'h0, frame_status[23:16] & m}, {24'h0, e});
      if (e[0]) chk(first_w, d[31:0]);
      if (m == 8'hFF) chk({16'h0, frame_status.count}, 32'(n + 5));
   endtask
   task automatic t_regs;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0000_0200);
      rd(8'h40, 32'h0);
      wr(8'h08, me[31:0]);
      wr(8'h0C, {16'h0, me[47:32]});
      rd(8'h08, me[31:0]);
   endtask
   task automatic t_good;
      for (int s = 1; s >= 0; s--) begin
         wr(8'h00, 32'(s));
         frame(me, 60, s[0], 0, 0, 8'hFF, 8'h01);
      end
   endtask
   task automatic t_bad;
      wr(8'h00, 32'h1);
      frame(me, 60, 1, 1, 0, 8'hFF, 8'h40);
      chk({31'h0, ev_err}, 32'h1);
      frame(me, 60, 1, 0, 1, 8'hFF, 8'h40);
      rd(8'h1C, 32'h2);
      rd(8'h1C, 32'h0);
   endtask
   // Multicast frames are dropped with an empty hash table and kept once every bit is set.
   task automatic t_filter;
      frame(other, 60, 1, 0, 0, 8'h41, 8'h00);
      wr(8'h00, 32'h9);
      frame(bc, 60, 1, 0, 0, 8'h45, 8'h05);
      wr(8'h00, 32'h3);
      frame(other, 60, 1, 0, 0, 8'h41, 8'h01);
      wr(8'h00, 32'h41);
      frame(me, 60, 1, 0, 0, 8'h61, 8'h20);
      rd(8'h24, 32'h1);
      wr(8'h00, 32'h5);
      frame(mc, 60, 1, 0, 0, 8'h03, 8'h02);
      wr(8'h10, 32'hFFFF_FFFF);
      wr(8'h14, 32'hFFFF_FFFF);
      frame(mc, 60, 1, 0, 0, 8'h03, 8'h03);
      wr(8'h00, 32'h1);
      frame(bc, 60, 1, 0, 0, 8'h45, 8'h05);
   endtask
   task automatic t_runt;
      wr(8'h00, 32'h1);
      frame(me, 20, 1, 0, 0, 8'h49, 8'h08);
      wr(8'h00, 32'h11);
      frame(me, 20, 1, 0, 0, 8'h49, 8'h09);
   endtask
   task automatic t_ovf;
      wr(8'h00, 32'h1);
      mem_full <= 1'b1;
      frame(me, 60, 1, 0, 0, 8'h21, 8'h20);
      mem_full <= 1'b0;
      chk({31'h0, ev_ovf}, 32'h1);
      rd(8'h24, 32'h1);
   endtask
   // Main sequence after the reset pulse.
   initial begin
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      t_regs();
      t_good();
      t_bad();
      t_filter();
      t_runt();
      t_ovf();
      chk({31'h0, ev_alt}, 32'h0);
      final_report();
   end
   // A hang ends the run as a failure at 800 us, well past the 30000-cycle wait of one frame.
   initial begin
      #800us;
      mismatches++;
      final_report();
   end
endmodule
